// [awsr_pkg.sv]
package awsr_pkg;
   // ==================================================
   // Register map
   localparam logic [7:0] AWSR_INACT_ADDR     = 8'h29;
   localparam logic [7:0] AWSR_SYSCTL1_ADDR   = 8'h2A;
   localparam logic [7:0] AWSR_SYSCTL2_ADDR   = 8'h2B;
   localparam logic [7:0] AWSR_INTCTL_ADDR    = 8'h2C;
   localparam logic [7:0] AWSR_INTEN_ADDR     = 8'h2D;
   localparam logic [7:0] AWSR_STATUS_ADDR    = 8'h0B;
   localparam logic [7:0] AWSR_INACT_RST      = 8'h00;
   localparam logic [7:0] AWSR_SYSCTL1_RST    = 8'h00;
   localparam logic [7:0] AWSR_SYSCTL2_RST    = 8'h00;
   localparam logic [7:0] AWSR_INTCTL_RST     = 8'h00;
   localparam logic [7:0] AWSR_INTEN_RST      = 8'h00;
   // ==================================================
   // System control one fields
   localparam int AWSR_SLP_RATE_HI  = 7;
   localparam int AWSR_SLP_RATE_LO  = 6;
   localparam int AWSR_WAKE_RATE_HI = 5;
   localparam int AWSR_WAKE_RATE_LO = 3;
   localparam int AWSR_FAST_READ_B  = 1;
   localparam int AWSR_ACTIVE_B     = 0;
   localparam logic [7:0] AWSR_SYSCTL1_MASK = 8'hFB;
   // System control two fields
   localparam int AWSR_SLP_OS_HI    = 4;
   localparam int AWSR_SLP_OS_LO    = 3;
   localparam int AWSR_AUTO_SLP_B   = 2;
   localparam int AWSR_WAKE_OS_HI   = 1;
   localparam int AWSR_WAKE_OS_LO   = 0;
   localparam logic [7:0] AWSR_SYSCTL2_MASK = 8'h1F;
   // Interrupt control / enable fields
   localparam int AWSR_FIFO_GATE_B  = 7;
   localparam int AWSR_SLPCHG_EN_B  = 7;
   // Wake select and enable bits for the four wake sources
   localparam int AWSR_WK_TRANS_B   = 6;
   localparam int AWSR_WK_ORIENT_B  = 5;
   localparam int AWSR_WK_TAP_B     = 4;
   localparam int AWSR_WK_FFMT_B    = 3;
   // ==================================================
   // Timing
   localparam int AWSR_CLK_HZ       = 50_000_000;
   localparam int AWSR_STEP_MS      = 320;
   localparam int AWSR_STEP_SLOW_MS = 640;
   localparam logic [2:0] AWSR_WAKE_RATE_SLOW = 3'h7;
   localparam int AWSR_STEP_CYC     = AWSR_CLK_HZ / 1000 * AWSR_STEP_MS;
   localparam int AWSR_STEP_SLOW_CYC =
      AWSR_CLK_HZ / 1000 * AWSR_STEP_SLOW_MS;
   // Oversampling schemes
   localparam logic [1:0] AWSR_OS_NORMAL = 2'h0;
   localparam logic [1:0] AWSR_OS_LNLP   = 2'h1;
   localparam logic [1:0] AWSR_OS_HIRES  = 2'h2;
   localparam logic [1:0] AWSR_OS_LP     = 2'h3;
   // Operating modes
   typedef enum logic [2:0] {
      AWSR_STANDBY = 3'b001,
      AWSR_WAKE    = 3'b010,
      AWSR_SLEEP   = 3'b100
   } awsr_mode_t;
endpackage

// [awsr_ctrl.sv]
`timescale 1ns/100ps
// What this block does
// - Auto sleep: wake rate to sleep rate
// - Eight-bit inactivity duration, reset zero
// - Step 320 ms, 640 ms at 1.56 Hz
// - Gate and four functions restart timer
// - Only four function events wake device
// - Enabled functions run at sleep rate
// - FIFO gate holds data until flush
// - No auto sleep: standby and wake only
// - Sleep change raises enabled interrupt
// - Control one field layout, zero default
// - Sleep rate overrides all block rates
// - Wake rate encodings, 800 Hz default
// - Active bit: zero standby, one active
// - Fast read skips low data bytes
// - Auto sleep enable at bit two
// - Separate wake and sleep oversampling
module awsr_ctrl
   import awsr_pkg::*;
#(
   parameter int STEP_CYC      = AWSR_STEP_CYC,
   parameter int STEP_SLOW_CYC = AWSR_STEP_SLOW_CYC
) (
   // Clock and reset
   input  wire logic       mclk_i,
   input  wire logic       srst_i,
   // Register port
   input  wire logic       reg_wr_i,
   input  wire logic [7:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic      [7:0] reg_rdata_o,
   // Function events, one-cycle pulses
   input  wire logic       transient_event_i,
   input  wire logic       orientation_event_i,
   input  wire logic       tap_event_i,
   input  wire logic       freefall_motion_event_i,
   input  wire logic       fifo_gate_event_i,
   input  wire logic       sample_ready_event_i,
   // FIFO
   input  wire logic       fifo_flush_i,
   output logic            fifo_accept_o,
   // Rate and mode outputs
   output logic            active_o,
   output logic            sleeping_o,
   output logic      [2:0] wake_rate_sel_o,
   output logic      [1:0] sleep_rate_sel_o,
   output logic            rate_is_sleep_o,
   output logic      [1:0] oversample_sel_o,
   output logic            fast_read_o,
   output logic            sleep_change_event_o
);
   // ==================================================
   // Registers
   logic [7:0] inact_r, inact_nxt;
   logic [7:0] ctl1_r, ctl1_nxt;
   logic [7:0] ctl2_r, ctl2_nxt;
   logic [7:0] ictl_r, ictl_nxt;
   logic [7:0] ien_r, ien_nxt;

   always_comb begin
      inact_nxt = inact_r;
      ctl1_nxt  = ctl1_r;
      ctl2_nxt  = ctl2_r;
      ictl_nxt  = ictl_r;
      ien_nxt   = ien_r;
      if (reg_wr_i) begin
         case (reg_addr_i)
            AWSR_INACT_ADDR:   inact_nxt = reg_wdata_i;
            AWSR_SYSCTL1_ADDR:
               ctl1_nxt = reg_wdata_i & AWSR_SYSCTL1_MASK;
            AWSR_SYSCTL2_ADDR:
               ctl2_nxt = reg_wdata_i & AWSR_SYSCTL2_MASK;
            AWSR_INTCTL_ADDR:  ictl_nxt = reg_wdata_i;
            AWSR_INTEN_ADDR:   ien_nxt  = reg_wdata_i;
            default:           inact_nxt = inact_r;
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         inact_r <= AWSR_INACT_RST;
         ctl1_r  <= AWSR_SYSCTL1_RST;
         ctl2_r  <= AWSR_SYSCTL2_RST;
         ictl_r  <= AWSR_INTCTL_RST;
         ien_r   <= AWSR_INTEN_RST;
      end else begin
         inact_r <= inact_nxt;
         ctl1_r  <= ctl1_nxt;
         ctl2_r  <= ctl2_nxt;
         ictl_r  <= ictl_nxt;
         ien_r   <= ien_nxt;
      end
   end

   // ==================================================
   // Mode machine and inactivity timer
   awsr_mode_t mode_r, mode_nxt;
   logic [31:0] pre_r, pre_nxt;
   logic [7:0]  steps_r, steps_nxt;
   logic        gate_r, gate_nxt;
   logic        chg_r, chg_nxt;
   logic        active, auto_en, restart, wake_ev, step_done;
   logic [3:0]  fn_ev;
   logic [31:0] step_len;

   assign active  = ctl1_r[AWSR_ACTIVE_B];
   assign auto_en = ctl2_r[AWSR_AUTO_SLP_B];
   assign fn_ev   = {transient_event_i, orientation_event_i,
                     tap_event_i, freefall_motion_event_i};
   // Only a function both enabled and selected for wake can wake
   assign wake_ev = |(fn_ev & ien_r[AWSR_WK_TRANS_B:AWSR_WK_FFMT_B]
                          & ictl_r[AWSR_WK_TRANS_B:AWSR_WK_FFMT_B]);
   // Sleep change and sample ready deliberately absent here
   assign restart = (|fn_ev) | fifo_gate_event_i;
   assign step_len = (ctl1_r[AWSR_WAKE_RATE_HI:AWSR_WAKE_RATE_LO]
                      == AWSR_WAKE_RATE_SLOW) ?
                     STEP_SLOW_CYC : STEP_CYC;
   assign step_done = (pre_r >= step_len - 32'd1);

   always_comb begin
      mode_nxt  = mode_r;
      pre_nxt   = pre_r;
      steps_nxt = steps_r;
      chg_nxt   = 1'b0;
      case (mode_r)
         AWSR_STANDBY: begin
            pre_nxt   = 32'd0;
            steps_nxt = 8'h00;
            if (active)
               mode_nxt = AWSR_WAKE;
         end
         AWSR_WAKE: begin
            if (!active) begin
               mode_nxt = AWSR_STANDBY;
            end else if (!auto_en || restart) begin
               pre_nxt   = 32'd0;
               steps_nxt = 8'h00;
            end else if (steps_r >= inact_r) begin
               mode_nxt  = AWSR_SLEEP;
               chg_nxt   = 1'b1;
               pre_nxt   = 32'd0;
               steps_nxt = 8'h00;
            end else if (step_done) begin
               pre_nxt   = 32'd0;
               steps_nxt = steps_r + 8'h01;
            end else begin
               pre_nxt = pre_r + 32'd1;
            end
         end
         AWSR_SLEEP: begin
            pre_nxt   = 32'd0;
            steps_nxt = 8'h00;
            if (!active) begin
               mode_nxt = AWSR_STANDBY;
            end else if (wake_ev || !auto_en) begin
               mode_nxt = AWSR_WAKE;
               chg_nxt  = 1'b1;
            end
         end
         default: begin
            mode_nxt = AWSR_STANDBY;
         end
      endcase
      // Gate closes on a sleep/wake change when the FIFO gate bit is set, and reopens only on flush
      gate_nxt = gate_r;
      if (chg_nxt && ictl_r[AWSR_FIFO_GATE_B])
         gate_nxt = 1'b1;
      else if (fifo_flush_i)
         gate_nxt = 1'b0;
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         mode_r  <= AWSR_STANDBY;
         pre_r   <= 32'd0;
         steps_r <= 8'h00;
         gate_r  <= 1'b0;
         chg_r   <= 1'b0;
      end else begin
         mode_r  <= mode_nxt;
         pre_r   <= pre_nxt;
         steps_r <= steps_nxt;
         gate_r  <= gate_nxt;
         chg_r   <= chg_nxt;
      end
   end

   // ==================================================
   // Outputs
   assign active_o         = active;
   assign sleeping_o       = (mode_r == AWSR_SLEEP);
   assign rate_is_sleep_o  = (mode_r == AWSR_SLEEP);
   assign wake_rate_sel_o  =
      ctl1_r[AWSR_WAKE_RATE_HI:AWSR_WAKE_RATE_LO];
   assign sleep_rate_sel_o = ctl1_r[AWSR_SLP_RATE_HI:AWSR_SLP_RATE_LO];
   // Functions keep running asleep; their rate and oversampling scheme change
   assign oversample_sel_o = (mode_r == AWSR_SLEEP) ?
                             ctl2_r[AWSR_SLP_OS_HI:AWSR_SLP_OS_LO] :
                             ctl2_r[AWSR_WAKE_OS_HI:AWSR_WAKE_OS_LO];
   assign fast_read_o      = ctl1_r[AWSR_FAST_READ_B];
   assign fifo_accept_o    = !gate_r;
   assign sleep_change_event_o = chg_r & ien_r[AWSR_SLPCHG_EN_B];

   always_comb begin
      case (reg_addr_i)
         AWSR_INACT_ADDR:   reg_rdata_o = inact_r;
         AWSR_SYSCTL1_ADDR: reg_rdata_o = ctl1_r;
         AWSR_SYSCTL2_ADDR: reg_rdata_o = ctl2_r;
         AWSR_INTCTL_ADDR:  reg_rdata_o = ictl_r;
         AWSR_INTEN_ADDR:   reg_rdata_o = ien_r;
         AWSR_STATUS_ADDR:  reg_rdata_o = {5'h00, gate_r,
                                           mode_r == AWSR_SLEEP,
                                           mode_r == AWSR_WAKE};
         default:           reg_rdata_o = 8'h00;
      endcase
   end

   // ==================================================
   // Checks
   std_rst_a: assert property (@(posedge mclk_i)
      srst_i |=> (reg_rdata_o == 8'h00 || reg_addr_i == AWSR_STATUS_ADDR)
                 && !sleeping_o)
      else $error("control state not cleared by reset");
   no_auto_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      !auto_en && !$past(auto_en) |-> !sleeping_o)
      else $error("slept with auto sleep off");
   sleep_cause_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      $rose(sleeping_o) |-> $past(auto_en) && $past(!restart))
      else $error("sleep without elapsed inactivity");
   wake_cause_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      sleeping_o && active && auto_en && wake_ev |=> !sleeping_o)
      else $error("wake event ignored");
   no_wake_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      sleeping_o && active && auto_en && !wake_ev |=> sleeping_o)
      else $error("woke without wake event");
   restart_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      mode_r == AWSR_WAKE && active && restart |=> steps_r == 8'h00)
      else $error("restart did not clear timer");
   standby_cnt_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      mode_r == AWSR_STANDBY |=> pre_r == 32'd0)
      else $error("timer ran in standby");
   gate_hold_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      !fifo_accept_o && !fifo_flush_i |=> !fifo_accept_o)
      else $error("fifo gate reopened without flush");
   chg_irq_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      $changed(sleeping_o) && active && $past(active)
         && ien_r[AWSR_SLPCHG_EN_B] |-> sleep_change_event_o)
      else $error("sleep change not signalled");
   step_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      steps_r != $past(steps_r) && steps_r != 8'h00
         |-> $past(step_done))
      else $error("step advanced early");

   sleep_c: cover property (@(posedge mclk_i) $rose(sleeping_o));
   wake_c: cover property (@(posedge mclk_i) $fell(sleeping_o) && active);
   gate_c: cover property (@(posedge mclk_i) $fell(fifo_accept_o));
endmodule // awsr_ctrl

// [awsr_host.sv]
`timescale 1ns/100ps
// ==================================================
// Host processor on the register port
module awsr_host
   import awsr_pkg::*;
(
   // Clock
   input  wire logic       mclk_i,
   // Register port, changed only on the falling edge
   output logic            reg_wr_o,
   output logic      [7:0] reg_addr_o,
   output logic      [7:0] reg_wdata_o
);
   initial begin
      reg_wr_o    = 1'b0;
      reg_addr_o  = 8'h00;
      reg_wdata_o = 8'h00;
   end
   // One byte per strobe; data is scrambled once the strobe drops
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk_i);
      reg_wr_o    = 1'b1;
      reg_addr_o  = a;
      reg_wdata_o = d;
      @(negedge mclk_i);
      reg_wr_o    = 1'b0;
      reg_wdata_o = ~d;
   endtask
   // Standby first, so fields never change while active
   // FIFO mode stays at bypass here, so fast read may change
   task automatic ctl1(input logic [7:0] d);
      wr(AWSR_SYSCTL1_ADDR, 8'h00);
      wr(AWSR_SYSCTL1_ADDR, d);
   endtask
   // A wake source needs both its enable and its select
   task automatic wake_src(input logic [7:0] en, input logic [7:0] sel);
      wr(AWSR_INTEN_ADDR, en);
      wr(AWSR_INTCTL_ADDR, sel);
   endtask
   // Read: point the address, data comes back combinationally
   task automatic pt(input logic [7:0] a);
      @(negedge mclk_i);
      reg_addr_o = a;
   endtask
endmodule // awsr_host

// [testbench.sv]
`timescale 1ns/100ps
// ==================================================
// Bench for the wake/sleep rate controller
module testbench
   import awsr_pkg::*;
;
   // Short step counts keep the run small
   localparam int STEP = 4;
   localparam int SLOW = 8;
   localparam int DUR  = 2;
   logic        mclk_i = 1'b0;
   logic        srst_i = 1'b1;
   logic        wr, act, slp, rsl, fr, sce, acc;
   logic        flush  = 1'b0;
   logic [7:0]  addr, wdata, rdata;
   logic [5:0]  evt    = 6'h00;
   logic [2:0]  wrs;
   logic [1:0]  srs, oss;
   int          fails = 0, comparisons = 0, cyc = 0, sce_n = 0;
   // Control one rows: written value, value read back
   logic [15:0] c1 [8] = '{16'h0400, 16'h4B4B, 16'h9692, 16'hD9D9,
                           16'h2723, 16'h6868, 16'hB2B2, 16'hFDF9};
   // Sleep rows: control one, event index (6 none), earliest sleep
   logic [23:0] sl [8] = '{24'h010608, 24'h010508, 24'h01040E,
      24'h01000E, 24'h01010E, 24'h01020E, 24'h01030E, 24'h390610};
   logic [7:0]  ra [6] = '{8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h30};

   always #10 mclk_i = ~mclk_i;

   awsr_host host (.mclk_i(mclk_i), .reg_wr_o(wr), .reg_addr_o(addr),
                   .reg_wdata_o(wdata));
   awsr_ctrl #(.STEP_CYC(STEP), .STEP_SLOW_CYC(SLOW)) uut (
      .mclk_i(mclk_i), .srst_i(srst_i), .reg_wr_i(wr),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .transient_event_i(evt[0]), .orientation_event_i(evt[1]),
      .tap_event_i(evt[2]), .freefall_motion_event_i(evt[3]),
      .fifo_gate_event_i(evt[4]), .sample_ready_event_i(evt[5]),
      .fifo_flush_i(flush), .fifo_accept_o(acc), .active_o(act),
      .sleeping_o(slp), .wake_rate_sel_o(wrs), .sleep_rate_sel_o(srs),
      .rate_is_sleep_o(rsl), .oversample_sel_o(oss), .fast_read_o(fr),
      .sleep_change_event_o(sce));

   task automatic test_done();
      if (fails == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e,
                      input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      host.pt(a);
      #1;
      chk("rdata", e, rdata);
   endtask
   task automatic until_slp(input logic v, output int n);
      n = 0;
      while (slp !== v && n < 200) begin
         @(negedge mclk_i);
         n++;
      end
   endtask
   task automatic reset_chk();
      chk("active", 0, act);
      chk("sleeping", 0, slp);
      chk("fifo_accept", 1, acc);
      foreach (ra[i])
         rdc(ra[i], 8'h00);
   endtask

   // Run needs about 300 cycles; the ceiling leaves wide margin
   always @(posedge mclk_i) begin
      cyc++;
      if (sce === 1'b1)
         sce_n++;
      if (cyc == 20000) begin
         fails++;
         test_done();
      end
   end

   initial begin
      int   n, m;
      logic e;
      repeat (16) @(negedge mclk_i);
      srst_i = 1'b0;
      reset_chk();
      // Auto sleep off and duration zero: must never sleep
      foreach (c1[i]) begin
         host.ctl1(c1[i][15:8]);
         @(negedge mclk_i);
         rdc(AWSR_SYSCTL1_ADDR, c1[i][7:0]);
         chk("wake_rate", c1[i][5:3], wrs);
         chk("sleep_rate", c1[i][7:6], srs);
         chk("fast_read", c1[i][1], fr);
         chk("active", c1[i][0], act);
         chk("sleeping", 0, slp);
      end
      host.wr(AWSR_INACT_ADDR, 8'(DUR));
      host.wr(AWSR_SYSCTL2_ADDR, 8'hF5);
      host.wake_src(8'hF8, 8'hD0);
      rdc(AWSR_INACT_ADDR, 8'(DUR));
      rdc(AWSR_SYSCTL2_ADDR, 8'h15);
      foreach (sl[i]) begin
         host.ctl1(sl[i][23:16]);
         for (int k = 0; k < 8; k++) begin
            @(negedge mclk_i);
            evt = (k % 3 == 0) ? 6'(1 << sl[i][11:8]) : 6'h00;
         end
         chk("wake_os", 2'b01, oss);
         m = sce_n;
         until_slp(1'b1, n);
         chk("sleep_time", 1, n + 8 >= sl[i][7:0]
             && n + 8 <= sl[i][7:0] + 5);
         repeat (3) @(negedge mclk_i);
         chk("rate_is_sleep", 1, rsl);
         chk("sleep_os", 2'b10, oss);
         chk("change_pulses", 1, sce_n - m);
         chk("fifo_accept", 0, acc);
         flush = 1'b1;
         @(negedge mclk_i);
         flush = 1'b0;
         @(negedge mclk_i);
         chk("fifo_reopen", 1, acc);
      end
      // Only transient and tap are selected for wake
      for (int i = 0; i < 6; i++) begin
         e = (i == 0 || i == 2);
         until_slp(1'b1, n);
         m = sce_n;
         @(negedge mclk_i);
         evt = 6'(1 << i);
         @(negedge mclk_i);
         evt = 6'h00;
         @(negedge mclk_i);
         chk("woken", e, !slp);
         if (e) begin
            until_slp(1'b1, n);
            chk("resleep", 1, n >= DUR * SLOW - 3);
            repeat (2) @(negedge mclk_i);
            chk("change_pulses", 2, sce_n - m);
         end
      end
      @(negedge mclk_i);
      srst_i = 1'b1;
      repeat (2) @(negedge mclk_i);
      srst_i = 1'b0;
      reset_chk();
      test_done();
   end
endmodule // testbench
